/* dv/part_pwm_load.sv */
`timescale 1ns/100ps
`default_nettype none
module part_pwm_load #(
	parameter int NUM_CH = 4
) (
	// Pin drivers
	input wire logic [NUM_CH-1:0] pwm_output_x,
	input wire logic [NUM_CH-1:0] pwm_output_x_oe,
	// Pad level
	output logic [NUM_CH-1:0] pin_level
);
	// Undriven pads fall to the pull-down, never keep the last level
	assign pin_level = pwm_output_x & pwm_output_x_oe;
endmodule
`default_nettype wire

/* dv/part_timer_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module part_timer_monitor #(
	parameter int NUM_CH = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Pins
	input wire logic [NUM_CH-1:0] pwm_output_x,
	input wire logic [NUM_CH-1:0] pwm_output_x_oe
);
	// ====
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	chk_ack_next: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
		else $error("ack late");
	chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	chk_oe_gates: assert property ((pwm_output_x & ~pwm_output_x_oe) == '0)
		else $error("waveform on disabled pin");
	chk_oe_write: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h0c
		|-> ##2 pwm_output_x_oe == $past(wb_dat_i[7:4], 2)) else $error("enable not applied");
	chk_unmapped_rd: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h1c |-> wb_dat_o == '0)
		else $error("unmapped read not zero");
	chk_force_rd0: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> !wb_dat_o[0])
		else $error("force bit reads back");
	chk_rst_quiet: assert property ($rose(rstn) |-> (pwm_output_x_oe == '0) [*2])
		else $error("pins driven after reset");
endmodule
bind part_timer part_timer_monitor #(.NUM_CH(NUM_CH)) u_mon (.sys_clk(sys_clk), .rstn(rstn),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.pwm_output_x(pwm_output_x), .pwm_output_x_oe(pwm_output_x_oe));
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ext = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h1;
	logic [31:0] wdat = 32'h0, dat_o, rd;
	logic ack;
	logic [3:0] pwm, oe, pin;
	int err_count = 0, samples_checked = 0, cycles = 0;
	always #12.5 sys_clk = ~sys_clk;
	part_timer dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.external_input_clock(ext), .pwm_output_x(pwm), .pwm_output_x_oe(oe));
	part_pwm_load load (.pwm_output_x(pwm), .pwm_output_x_oe(oe), .pin_level(pin));
	// ====
	// Helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do @(posedge sys_clk); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		check(rd, {24'h0, e}, "read");
	endtask
	task automatic pins(input logic [3:0] e);
		repeat (2) @(posedge sys_clk);
		check({28'h0, pin}, {28'h0, e}, "pins");
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ====
	// Scenarios
	task automatic t_reset;
		for (int a = 0; a <= 28; a += 4) rchk(a[7:0], 8'h00);
		bus(1'b1, 8'h40, 8'h5a);
		rchk(8'h40, 8'h00);
		// Write with lane 0 off must be ignored
		sel <= 4'h0;
		bus(1'b1, 8'h08, 8'h77);
		sel <= 4'h1;
		rchk(8'h08, 8'h00);
		$display("reset test done");
	endtask
	// Each run ends on a whole number of counter steps: 5 << n ticks
	task automatic t_count;
		for (int n = 0; n < 8; n++) begin
			bus(1'b1, 8'h04, 8'h20);
			bus(1'b1, 8'h00, {3'h0, n[2:0], 2'h2});
			repeat ((5 << n) - 3) @(posedge sys_clk);
			bus(1'b1, 8'h00, 8'h00);
			rchk(8'h04, 8'h25);
		end
		$display("count test done");
	endtask
	task automatic t_reload;
		bus(1'b1, 8'h08, 8'h80);
		bus(1'b1, 8'h04, 8'hfe);
		bus(1'b1, 8'h00, 8'h02);
		bus(1'b1, 8'h00, 8'h00);
		rchk(8'h04, 8'h81);
		rchk(8'h00, 8'h80);
		bus(1'b1, 8'h08, 8'h33);
		bus(1'b1, 8'h00, 8'h03);
		// Clears overflow marker; force bit alone does nothing
		bus(1'b1, 8'h00, 8'h81);
		rchk(8'h04, 8'h36);
		rchk(8'h00, 8'h00);
		bus(1'b1, 8'h04, 8'h00);
		bus(1'b1, 8'h00, 8'h22);
		repeat (4) begin
			repeat (4) @(posedge sys_clk);
			ext <= 1'b1;
			repeat (4) @(posedge sys_clk);
			ext <= 1'b0;
		end
		repeat (6) @(posedge sys_clk);
		bus(1'b1, 8'h00, 8'h20);
		rchk(8'h04, 8'h04);
		rchk(8'h00, 8'h20);
		$display("reload test done");
	endtask
	task automatic t_pwm;
		bus(1'b1, 8'h10, 8'h00);
		bus(1'b1, 8'h14, 8'h01);
		bus(1'b1, 8'h18, 8'h02);
		bus(1'b1, 8'h1c, 8'hff);
		rchk(8'h1c, 8'hff);
		bus(1'b1, 8'h04, 8'h01);
		bus(1'b1, 8'h0c, 8'hf0);
		pins(4'h0);
		bus(1'b1, 8'h08, 8'h00);
		bus(1'b1, 8'h04, 8'hfe);
		bus(1'b1, 8'h00, 8'h02);
		bus(1'b1, 8'h00, 8'h00);
		pins(4'he);
		bus(1'b1, 8'h0c, 8'hf5);
		pins(4'hb);
		bus(1'b1, 8'h0c, 8'h35);
		pins(4'h3);
		check({28'h0, oe}, 32'h3, "enable");
		$display("pwm test done");
	endtask
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_count++;
			$display("ERROR %0t timeout", $time);
			print_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_reset();
		t_count();
		t_reload();
		t_pwm();
		print_verdict();
	end
endmodule
`default_nettype wire

/* hw/part_pwm_chan.sv */
`timescale 1ns/100ps
`default_nettype none
module part_pwm_chan (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Counter side
	input wire logic [part_pkg::CNT_W-1:0] counter,
	input wire logic reload_tick,
	// Configuration
	input wire logic [part_pkg::CNT_W-1:0] duty,
	input wire logic polarity,
	input wire logic enable,
	// Pin side
	output logic pwm_out,
	output logic pwm_oe
);
	// ==================================================
	// Hidden compare value, refreshed only at overflow
	logic [part_pkg::CNT_W-1:0] compare_value;
	logic high_phase;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			compare_value <= part_pkg::RST_BYTE;
		end else if (reload_tick) begin
			compare_value <= duty;
		end
	end

	assign high_phase = (counter <= compare_value);

	// ==================================================
	// Pin drive; polarity acts without waiting for overflow
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_out <= 1'b0;
			pwm_oe <= 1'b0;
		end else begin
			pwm_out <= enable & (high_phase ^ polarity);
			pwm_oe <= enable;
		end
	end
endmodule
`default_nettype wire

/* hw/part_timer.sv */
// What this block does
// - Free-running 8-bit counter steps by one on each prescaled clock tick.
// - Software reads or writes the counter any time via counter_access.
// - Overflow reloads counter from auto_reload_value; prescaler untouched.
// - 7-bit prescaler, prescale_select picks tap: divide by two to the field.
// - external_clock_select chooses CPU clock or external input clock.
// - Enable bit low freezes prescaler and counter; high lets counting run.
// - Reset clears counter and prescaler and selects CPU clock.
// - Reload value, then force reload plus enable, loads counter from reload value.
// - Any counter initialisation clears the prescaler; prescaler is not accessible.
// - Counter compared continuously against four channel compare values.
// - Hidden compare values load from duty registers at each overflow.
// - Output control bits 7:4 enable each channel output onto its pin.
// - Bits 3:0 pick polarity: zero gives high while counter at or below compare.
// - Polarity change inverts the output at once, not at overflow.
// - Duty value sets second edge; reload value sets common first edge.
`timescale 1ns/100ps
`default_nettype none
module part_timer #(
	parameter int NUM_CH = part_pkg::NUM_CH
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [part_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [part_pkg::SEL_BYTES-1:0] wb_sel_i,
	input wire logic [part_pkg::DATA_W-1:0] wb_dat_i,
	output logic [part_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// External timer clock pin
	input wire logic external_input_clock,
	// PWM pins
	output logic [NUM_CH-1:0] pwm_output_x,
	output logic [NUM_CH-1:0] pwm_output_x_oe
);
	// ==================================================
	// Reset release
	logic rst_meta_n;
	logic rst_n;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// ==================================================
	// Registers
	logic [part_pkg::CNT_W-1:0] counter;
	logic [part_pkg::CNT_W-1:0] auto_reload_value;
	logic [part_pkg::CNT_W-1:0] pwm_output_control;
	logic [part_pkg::CNT_W-1:0] channel_duty_cycle [NUM_CH];
	logic [part_pkg::PRESC_W-1:0] prescaler;
	logic [part_pkg::SEL_W-1:0] prescale_select;
	logic counter_clock_enable;
	logic external_clock_select;
	logic overflow_seen;

	// ==================================================
	// Wishbone decode
	part_pkg::part_bus_state_t bus_state;
	logic bus_req;
	logic wr_strobe;
	logic wr_lane;
	logic [part_pkg::CNT_W-1:0] wr_byte;
	logic hit_ctrl;
	logic hit_counter;
	logic hit_reload;
	logic hit_out_ctrl;
	logic [NUM_CH-1:0] hit_duty;

	assign bus_req = wb_cyc_i & wb_stb_i;
	assign wr_lane = wb_sel_i[0];
	assign wr_byte = wb_dat_i[part_pkg::CNT_W-1:0];
	// Write acts on the edge where ack is sampled high
	assign wr_strobe = bus_req & wb_we_i & wr_lane & (bus_state == part_pkg::BUS_ACK);
	assign hit_ctrl = (wb_adr_i == part_pkg::OFS_CTRL_STATUS);
	assign hit_counter = (wb_adr_i == part_pkg::OFS_COUNTER);
	assign hit_reload = (wb_adr_i == part_pkg::OFS_RELOAD);
	assign hit_out_ctrl = (wb_adr_i == part_pkg::OFS_OUT_CTRL);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_duty_hit
			localparam logic [part_pkg::ADDR_W-1:0] DUTY_OFS =
				part_pkg::ADDR_W'(part_pkg::OFS_DUTY0 + gi * part_pkg::OFS_DUTY_STEP);
			assign hit_duty[gi] = (wb_adr_i == DUTY_OFS);
		end
	endgenerate

	// One wait state, then ack for one cycle; every address answers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_state <= part_pkg::BUS_IDLE;
		end else begin
			case (bus_state)
				part_pkg::BUS_IDLE: begin
					if (bus_req) begin
						bus_state <= part_pkg::BUS_ACK;
					end
				end
				part_pkg::BUS_ACK: begin
					bus_state <= part_pkg::BUS_IDLE;
				end
				default: begin
					bus_state <= part_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req & (bus_state == part_pkg::BUS_IDLE);
		end
	end

	// ==================================================
	// Read data, unmapped addresses read zero
	logic [part_pkg::DATA_W-1:0] next_rd_data;
	logic [part_pkg::CNT_W-1:0] ctrl_view;

	always_comb begin
		ctrl_view = part_pkg::RST_BYTE;
		ctrl_view[part_pkg::BIT_CLK_ENABLE] = counter_clock_enable;
		ctrl_view[part_pkg::BIT_PRESC_HI:part_pkg::BIT_PRESC_LO] = prescale_select;
		ctrl_view[part_pkg::BIT_EXT_CLK] = external_clock_select;
		ctrl_view[part_pkg::BIT_OVF_SEEN] = overflow_seen;
	end

	always_comb begin
		next_rd_data = part_pkg::RD_ZERO;
		if (hit_ctrl) begin
			next_rd_data[part_pkg::CNT_W-1:0] = ctrl_view;
		end else if (hit_counter) begin
			next_rd_data[part_pkg::CNT_W-1:0] = counter;
		end else if (hit_reload) begin
			next_rd_data[part_pkg::CNT_W-1:0] = auto_reload_value;
		end else if (hit_out_ctrl) begin
			next_rd_data[part_pkg::CNT_W-1:0] = pwm_output_control;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (hit_duty[i]) begin
					next_rd_data[part_pkg::CNT_W-1:0] = channel_duty_cycle[i];
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= part_pkg::RD_ZERO;
		end else if (bus_req & ~wb_we_i & (bus_state == part_pkg::BUS_IDLE)) begin
			wb_dat_o <= next_rd_data;
		end
	end

	// ==================================================
	// Configuration registers
	logic force_reload_req;

	assign force_reload_req = wr_strobe & hit_ctrl & wr_byte[part_pkg::BIT_FORCE_RELOAD]
		& wr_byte[part_pkg::BIT_CLK_ENABLE];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			counter_clock_enable <= 1'b0;
			prescale_select <= '0;
			external_clock_select <= 1'b0;
		end else if (wr_strobe & hit_ctrl) begin
			counter_clock_enable <= wr_byte[part_pkg::BIT_CLK_ENABLE];
			prescale_select <= wr_byte[part_pkg::BIT_PRESC_HI:part_pkg::BIT_PRESC_LO];
			external_clock_select <= wr_byte[part_pkg::BIT_EXT_CLK];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_reload_value <= part_pkg::RST_BYTE;
		end else if (wr_strobe & hit_reload) begin
			auto_reload_value <= wr_byte;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_output_control <= part_pkg::RST_BYTE;
		end else if (wr_strobe & hit_out_ctrl) begin
			pwm_output_control <= wr_byte;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				channel_duty_cycle[i] <= part_pkg::RST_BYTE;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (wr_strobe & hit_duty[i]) begin
					channel_duty_cycle[i] <= wr_byte;
				end
			end
		end
	end

	// ==================================================
	// External clock: synchronise, then count rising edges
	// Usable only well below half the system clock rate
	logic ext_meta;
	logic ext_sync;
	logic ext_prev;
	logic ext_rise;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_meta <= external_input_clock;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	assign ext_rise = ext_sync & ~ext_prev;

	// ==================================================
	// Prescaler and counter ticks
	logic input_tick;
	logic [part_pkg::PRESC_W-1:0] tap_mask;
	logic counter_tick;
	logic overflow_tick;
	logic counter_write;

	assign input_tick = counter_clock_enable & (external_clock_select ? ext_rise : 1'b1);
	// Tap n fires once every 2^n input ticks
	assign tap_mask = part_pkg::PRESC_W'((part_pkg::PRESC_ONE << prescale_select) - part_pkg::PRESC_ONE);
	assign counter_tick = input_tick & ((prescaler & tap_mask) == tap_mask);
	assign overflow_tick = counter_tick & (counter == part_pkg::CNT_MAX);
	assign counter_write = wr_strobe & hit_counter;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prescaler <= part_pkg::PRESC_CLEAR;
		end else if (counter_write | force_reload_req) begin
			prescaler <= part_pkg::PRESC_CLEAR;
		end else if (input_tick) begin
			prescaler <= part_pkg::PRESC_W'(prescaler + part_pkg::PRESC_ONE);
		end
	end

	// Software initialisation wins over a tick in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			counter <= part_pkg::RST_BYTE;
		end else if (counter_write) begin
			counter <= wr_byte;
		end else if (force_reload_req) begin
			counter <= auto_reload_value;
		end else if (overflow_tick) begin
			counter <= auto_reload_value;
		end else if (counter_tick) begin
			counter <= part_pkg::CNT_W'(counter + part_pkg::CNT_ONE);
		end
	end

	// Sticky overflow marker, cleared by a control write with the bit set; overflow wins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			overflow_seen <= 1'b0;
		end else if (overflow_tick) begin
			overflow_seen <= 1'b1;
		end else if (wr_strobe & hit_ctrl & wr_byte[part_pkg::BIT_OVF_SEEN]) begin
			overflow_seen <= 1'b0;
		end
	end

	// ==================================================
	// PWM channels
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
			part_pwm_chan u_chan (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.counter(counter),
				.reload_tick(overflow_tick),
				.duty(channel_duty_cycle[gi]),
				.polarity(pwm_output_control[part_pkg::BIT_POL_LO + gi]),
				.enable(pwm_output_control[part_pkg::BIT_OE_LO + gi]),
				.pwm_out(pwm_output_x[gi]),
				.pwm_oe(pwm_output_x_oe[gi])
			);
		end
	endgenerate
endmodule
`default_nettype wire

/* include/part_pkg.sv */
`default_nettype none
package part_pkg;
	// ==================================================
	// Sizes
	localparam int CNT_W = 8;
	localparam int PRESC_W = 7;
	localparam int SEL_W = 3;
	localparam int NUM_CH = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SEL_BYTES = 4;

	// ==================================================
	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_COUNTER = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_OUT_CTRL = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_DUTY0 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_DUTY_STEP = 8'h04;

	// ==================================================
	// timer_control_status fields
	localparam int BIT_FORCE_RELOAD = 0;
	localparam int BIT_CLK_ENABLE = 1;
	localparam int BIT_PRESC_LO = 2;
	localparam int BIT_PRESC_HI = 4;
	localparam int BIT_EXT_CLK = 5;
	localparam int BIT_OVF_SEEN = 7;

	// pwm_output_control fields
	localparam int BIT_OE_LO = 4;
	localparam int BIT_OE_HI = 7;
	localparam int BIT_POL_LO = 0;
	localparam int BIT_POL_HI = 3;

	// ==================================================
	// Values
	localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
	localparam logic [CNT_W-1:0] RST_BYTE = 8'h00;
	localparam logic [PRESC_W-1:0] PRESC_CLEAR = 7'h00;
	localparam logic [PRESC_W-1:0] PRESC_ONE = 7'h01;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

	// Bus handshake states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} part_bus_state_t;
endpackage
`default_nettype wire
